// ==== verilog/sacc_pkg.sv ====
package sacc_pkg;
    // Trigger source select codes.
    localparam logic [1:0] TRIG_SOFT = 2'h0;
    localparam logic [1:0] TRIG_TMR2 = 2'h1;
    localparam logic [1:0] TRIG_TMR3 = 2'h2;
    localparam logic [1:0] TRIG_EXT = 2'h3;
    // Gain codes: 0 means 0.5, then 1, 2, 4, 8, 16.
    localparam logic [2:0] GAIN_MAX = 3'h5;
    // Channel eight is the internal temperature sensor.
    localparam logic [3:0] CHAN_TEMP = 4'h8;
    localparam logic [3:0] CHAN_LAST = 4'h8;
    // Result widths.
    localparam int RES_FULL = 12;
    localparam int RES_REDUCED = 10;
    localparam int RES_WORD = 16;
    // Converter timing in clock cycles at 40 MHz.
    localparam int CLK_PERIOD_NS = 25;
    localparam int CONV_TIME_NS = 2000;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam logic [15:0] RESULT_RST = 16'h0000;
endpackage

// ==== verilog/sacc_justify.sv ====
`timescale 1ns/1ps
`default_nettype none
// Places a raw result in a 16-bit word, right or left aligned.
module sacc_justify #(
    parameter int RES_BITS = 12
) (
    // Raw data and alignment
    input wire logic [RES_BITS-1:0] raw,
    input wire logic left_align,
    // Aligned word
    output logic [15:0] word
);
    always_comb begin
        if (left_align) begin
            word = {raw, {(sacc_pkg::RES_WORD - RES_BITS){1'b0}}};
        end else begin
            word = {{(sacc_pkg::RES_WORD - RES_BITS){1'b0}}, raw};
        end
    end
endmodule
`default_nettype wire

// ==== verilog/sacc_ctrl.sv ====
// Behaviour
// - Start on software command, timer 2 or 3 overflow, or external edge.
// - Completion sets done flag; interrupt only if completion enabled.
// - Result latched on completion, held until the next completion.
// - Result right or left aligned in 16 bits, unused bits zero.
// - Window flag raised for result inside or outside limits as chosen.
// - Background mode masks the completion interrupt; each conversion still needs a trigger.
// - Nine channel select, eight pins plus temperature sensor.
// - Each external pin pair is single-ended or differential by one bit.
// - Gain field 0.5 to 16 in powers of two drives amplifier code.
// - Shutdown bit stops all conversions from starting.
// - Reference chosen from first analog output or reference pin.
`timescale 1ns/1ps
`default_nettype none
module sacc_ctrl #(
    parameter int RES_BITS = sacc_pkg::RES_FULL,
    parameter int CONV_CYC = sacc_pkg::CONV_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Configuration
    input wire logic enable,
    input wire logic [1:0] trig_sel,
    input wire logic soft_start,
    input wire logic tmr2_ovf,
    input wire logic tmr3_ovf,
    input wire logic ext_start,
    input wire logic [3:0] chan_sel,
    input wire logic [3:0] diff_pair,
    input wire logic [2:0] gain_sel,
    input wire logic ref_from_dac,
    input wire logic left_align,
    input wire logic done_irq_en,
    input wire logic background,
    input wire logic win_inside,
    input wire logic [15:0] win_high,
    input wire logic [15:0] win_low,
    input wire logic done_clr,
    input wire logic win_clr,
    // Analog core
    input wire logic [RES_BITS-1:0] core_data,
    output logic core_start,
    output logic core_powerdown,
    output logic [3:0] mux_pos,
    output logic [3:0] mux_neg,
    output logic mux_diff,
    output logic [2:0] pga_code,
    output logic ref_sel_dac,
    // Status
    output logic busy,
    output logic done_flag,
    output logic win_flag,
    output logic done_irq,
    output logic [15:0] result
);
    typedef enum logic [1:0] {
        SACC_IDLE = 2'b01,
        SACC_CONV = 2'b10
    } sacc_state_t;

    sacc_state_t state_reg, state_next;
    logic [15:0] cnt_reg, cnt_next;
    logic [15:0] result_reg, result_next;
    logic done_reg, done_next;
    logic win_reg, win_next;
    logic ext_reg, ext_next;
    logic start_cmd;
    logic finish;
    logic in_range;
    logic win_hit;
    logic [15:0] aligned;
    logic [2 * $bits(diff_pair) - 1:0] pin_diff;

    sacc_justify #(.RES_BITS(RES_BITS)) u_justify (
        .raw(core_data),
        .left_align(left_align),
        .word(aligned)
    );

    // Trigger selection; external start is rising-edge detected.
    always_comb begin
        case (trig_sel)
            sacc_pkg::TRIG_SOFT: start_cmd = soft_start;
            sacc_pkg::TRIG_TMR2: start_cmd = tmr2_ovf;
            sacc_pkg::TRIG_TMR3: start_cmd = tmr3_ovf;
            sacc_pkg::TRIG_EXT: start_cmd = ext_start & ~ext_reg;
            default: start_cmd = 1'b0;
        endcase
    end

    assign finish = (state_reg == SACC_CONV) && (cnt_reg == 16'h0000);
    // Limits are compared against the justified word, both inclusive.
    assign in_range = (aligned >= win_low) && (aligned <= win_high);
    assign win_hit = win_inside ? in_range : ~in_range;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        result_next = result_reg;
        ext_next = ext_start;
        case (state_reg)
            SACC_IDLE: begin
                // Shutdown blocks starts even if a trigger fires.
                if (enable && start_cmd) begin
                    state_next = SACC_CONV;
                    cnt_next = 16'(CONV_CYC - 1);
                end
            end
            SACC_CONV: begin
                if (cnt_reg != 16'h0000) begin
                    cnt_next = cnt_reg - 16'h0001;
                end else begin
                    result_next = aligned;
                    state_next = SACC_IDLE;
                end
            end
            default: state_next = SACC_IDLE;
        endcase
    end

    // Clears come first so a same-cycle set wins.
    always_comb begin
        done_next = done_reg;
        win_next = win_reg;
        if (done_clr) begin
            done_next = 1'b0;
        end
        if (win_clr) begin
            win_next = 1'b0;
        end
        if (finish) begin
            done_next = 1'b1;
        end
        if (finish && win_hit) begin
            win_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= SACC_IDLE;
            cnt_reg <= 16'h0000;
            result_reg <= sacc_pkg::RESULT_RST;
            ext_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            result_reg <= result_next;
            ext_reg <= ext_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            done_reg <= 1'b0;
            win_reg <= 1'b0;
        end else begin
            done_reg <= done_next;
            win_reg <= win_next;
        end
    end

    // Each pin carries the differential bit of the pair it belongs to.
    for (genvar k = 0; k < $bits(diff_pair); k++) begin : g_pair
        assign pin_diff[2 * k] = diff_pair[k];
        assign pin_diff[2 * k + 1] = diff_pair[k];
    end

    // Pairs are 0/1, 2/3, 4/5, 6/7; the even pin is the positive leg.
    always_comb begin
        mux_pos = chan_sel;
        mux_neg = chan_sel;
        mux_diff = 1'b0;
        if (chan_sel > sacc_pkg::CHAN_LAST) begin
            mux_pos = sacc_pkg::CHAN_TEMP;
            mux_neg = sacc_pkg::CHAN_TEMP;
        end else if (chan_sel != sacc_pkg::CHAN_TEMP
                     && pin_diff[chan_sel[2:0]]) begin
            mux_pos = {chan_sel[3:1], 1'b0};
            mux_neg = {chan_sel[3:1], 1'b1};
            mux_diff = 1'b1;
        end
    end

    // Codes above 16x saturate to 16x.
    assign pga_code = (gain_sel > sacc_pkg::GAIN_MAX) ?
        sacc_pkg::GAIN_MAX : gain_sel;
    assign ref_sel_dac = ref_from_dac;
    assign core_powerdown = ~enable;
    assign core_start = (state_reg == SACC_IDLE) && enable && start_cmd;
    assign busy = (state_reg == SACC_CONV);
    assign done_flag = done_reg;
    assign win_flag = win_reg;
    // Background mode still records completion but never asks for service.
    assign done_irq = done_reg & done_irq_en & ~background;
    assign result = result_reg;

    a_busy_hold: assert property (
        @(posedge ref_clk) disable iff (rst)
        core_start |=> busy [*2])
        else $error("busy did not hold after start");
    a_done_sets: assert property (
        @(posedge ref_clk) disable iff (rst)
        finish |=> done_flag)
        else $error("done flag not set on completion");
    a_irq_gate: assert property (
        @(posedge ref_clk) disable iff (rst)
        done_irq |-> done_flag && done_irq_en && !background)
        else $error("interrupt without enable");
    a_result_latch: assert property (
        @(posedge ref_clk) disable iff (rst)
        finish |=> result == $past(aligned))
        else $error("result not latched");
    a_result_stable: assert property (
        @(posedge ref_clk) disable iff (rst)
        !finish |=> $stable(result))
        else $error("result changed without completion");
    a_shutdown_block: assert property (
        @(posedge ref_clk) disable iff (rst)
        !enable |-> !core_start)
        else $error("start during shutdown");
    a_win_sets: assert property (
        @(posedge ref_clk) disable iff (rst)
        finish && win_hit |=> win_flag)
        else $error("window flag missed");
    a_bg_quiet: assert property (
        @(posedge ref_clk) disable iff (rst)
        background |-> !done_irq)
        else $error("background raised an interrupt");
    a_trig_ignored: assert property (
        @(posedge ref_clk) disable iff (rst)
        busy |-> !core_start)
        else $error("start during conversion");
    a_conv_len: assert property (
        @(posedge ref_clk) disable iff (rst)
        core_start |=> busy ##1 !finish)
        else $error("conversion too short");
    a_gain_range: assert property (
        @(posedge ref_clk) disable iff (rst)
        pga_code <= sacc_pkg::GAIN_MAX)
        else $error("gain code out of range");
    a_diff_pair: assert property (
        @(posedge ref_clk) disable iff (rst)
        mux_diff |-> mux_neg == mux_pos + 4'h1 && !mux_pos[0])
        else $error("bad differential pair");
    a_done_only: assert property (
        @(posedge ref_clk) disable iff (rst)
        $rose(done_flag) |-> $past(finish))
        else $error("done flag set without completion");
    a_win_only: assert property (
        @(posedge ref_clk) disable iff (rst)
        $rose(win_flag) |-> $past(finish) && $past(win_hit))
        else $error("window flag set without a hit");
    a_trig_no_restart: assert property (
        @(posedge ref_clk) disable iff (rst)
        busy && start_cmd && !finish
            |=> busy && cnt_reg == $past(cnt_reg) - 16'h0001)
        else $error("trigger disturbed a running conversion");
    a_conv_load: assert property (
        @(posedge ref_clk) disable iff (rst)
        core_start |=> cnt_reg == 16'(CONV_CYC - 1))
        else $error("conversion length not loaded");
    a_finish_idle: assert property (
        @(posedge ref_clk) disable iff (rst)
        finish |=> !busy)
        else $error("busy held past the result latch");
    a_busy_start: assert property (
        @(posedge ref_clk) disable iff (rst)
        !busy && enable && start_cmd |-> core_start)
        else $error("selected trigger not taken");
    a_clr_done: assert property (
        @(posedge ref_clk) disable iff (rst)
        done_clr && !finish |=> !done_flag)
        else $error("done flag survived its clear");
    a_gain_pass: assert property (
        @(posedge ref_clk) disable iff (rst)
        gain_sel <= sacc_pkg::GAIN_MAX |-> pga_code == gain_sel)
        else $error("gain code not passed through");
    a_temp_select: assert property (
        @(posedge ref_clk) disable iff (rst)
        chan_sel >= sacc_pkg::CHAN_TEMP
            |-> mux_pos == sacc_pkg::CHAN_TEMP && !mux_diff)
        else $error("temperature channel not selected");
    a_power_follow: assert property (
        @(posedge ref_clk) disable iff (rst)
        core_powerdown == !enable)
        else $error("power down does not follow enable");
    a_ref_follow: assert property (
        @(posedge ref_clk) disable iff (rst)
        ref_sel_dac == ref_from_dac)
        else $error("reference select does not follow");
    a_right_zero: assert property (
        @(posedge ref_clk) disable iff (rst)
        !left_align |-> aligned >> RES_BITS == 16'h0000)
        else $error("right aligned word has upper bits set");
    a_left_zero: assert property (
        @(posedge ref_clk) disable iff (rst)
        left_align |-> aligned << RES_BITS == 16'h0000)
        else $error("left aligned word has lower bits set");

    c_conv: cover property (@(posedge ref_clk) disable iff (rst) finish);
    c_win: cover property (@(posedge ref_clk) disable iff (rst)
        finish && win_hit && background);
    c_ext: cover property (@(posedge ref_clk) disable iff (rst)
        core_start && trig_sel == sacc_pkg::TRIG_EXT);
    c_diff: cover property (@(posedge ref_clk) disable iff (rst)
        finish && mux_diff);
    c_ignored: cover property (@(posedge ref_clk) disable iff (rst)
        busy && start_cmd);
endmodule
`default_nettype wire

// ==== verif/sacc_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sacc_core_model (
    // Clock and handshake
    input wire logic ref_clk,
    input wire logic core_start,
    input wire logic busy,
    // Value to convert and its result
    input wire logic [11:0] sample,
    output logic [11:0] core_data
);
    logic [11:0] held_reg;
    always_ff @(posedge ref_clk) begin
        if (core_start) begin
            held_reg <= sample;
        end
    end
    // Outside a conversion the data is invalid, so a stale value cannot pass.
    assign core_data = busy ? held_reg : ~held_reg;
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int CONV = 3;
    // Starts stay at least this far apart to respect the 100 ksps limit.
    localparam int GAP = 400;
    logic ref_clk = 1'b0, rst = 1'b1, enable = 1'b1, left_align = 1'b0;
    logic soft_start = 1'b0, tmr2_ovf = 1'b0, tmr3_ovf = 1'b0;
    logic ext_start = 1'b0, ref_from_dac = 1'b0, done_irq_en = 1'b0;
    logic background = 1'b0, win_inside = 1'b0, done_clr = 1'b0;
    logic win_clr = 1'b0, core_start, core_powerdown, mux_diff, busy;
    logic done_flag, win_flag, done_irq, ref_sel_dac;
    logic [1:0] trig_sel = 2'h0;
    logic [3:0] chan_sel = 4'h0, diff_pair = 4'h0, mux_pos, mux_neg;
    logic [2:0] gain_sel = 3'h0, pga_code;
    logic [11:0] sample = 12'h000, core_data;
    logic [15:0] win_high = 16'h0000, win_low = 16'h0000, result;
    int mismatches = 0, total_checks = 0, seed;
    always #12.5 ref_clk = ~ref_clk;
    sacc_ctrl #(.RES_BITS(12), .CONV_CYC(CONV)) u_dut (.ref_clk, .rst,
        .enable, .trig_sel, .soft_start, .tmr2_ovf, .tmr3_ovf, .ext_start,
        .chan_sel, .diff_pair, .gain_sel, .ref_from_dac, .left_align,
        .done_irq_en, .background, .win_inside, .win_high, .win_low,
        .done_clr, .win_clr, .core_data, .core_start, .core_powerdown,
        .mux_pos, .mux_neg, .mux_diff, .pga_code, .ref_sel_dac, .busy,
        .done_flag, .win_flag, .done_irq, .result);
    sacc_core_model u_core (.ref_clk, .core_start, .busy, .sample,
        .core_data);
    function automatic logic [15:0] just16(logic [11:0] v, logic la);
        return la ? {v, 4'h0} : {4'h0, v};
    endfunction
    function automatic logic hit(logic [15:0] w, hi, lo, logic ins);
        return ((w >= lo) && (w <= hi)) == ins;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        if (mismatches == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic conv(input logic [1:0] t, input logic [11:0] v,
            input logic bg, input logic eq);
        logic la, ie, ins;
        logic [15:0] w, hi, lo;
        int n, s;
        la = 1'($urandom);
        ie = 1'($urandom);
        ins = 1'($urandom);
        w = just16(v, la);
        hi = eq ? w : 16'($urandom);
        lo = eq ? w : hi >> 2;
        n = 0;
        s = 0;
        @(posedge ref_clk);
        trig_sel <= t;
        sample <= v;
        left_align <= la;
        background <= bg;
        done_irq_en <= ie;
        win_inside <= ins;
        win_high <= hi;
        win_low <= lo;
        done_clr <= 1'b1;
        win_clr <= 1'b1;
        // Unselected sources fire first, so a wrong select starts early.
        {ext_start, tmr3_ovf, tmr2_ovf, soft_start} <= ~(4'h1 << t);
        @(posedge ref_clk);
        done_clr <= 1'b0;
        win_clr <= 1'b0;
        {ext_start, tmr3_ovf, tmr2_ovf, soft_start} <= 4'h1 << t;
        for (int i = 0; i < 40; i++) begin
            #1;
            if (i == 0) chk(16'({done_flag, win_flag}), 16'h0000);
            if (core_start === 1'b1) s++;
            if (busy === 1'b1) n++;
            @(posedge ref_clk);
            if (i == 1) {ext_start, tmr3_ovf, tmr2_ovf, soft_start} <= 4'h0;
        end
        #1;
        chk(16'(s), 16'h0001);
        chk(16'(n), 16'(CONV));
        chk(result, w);
        chk(16'(win_flag), 16'(hit(w, hi, lo, ins)));
        chk(16'(done_flag), 16'h0001);
        chk(16'(done_irq), {15'h0000, ie & ~bg});
        repeat (GAP) @(posedge ref_clk);
    endtask
    initial begin
        seed = $urandom(32'hD2ED3FC6);
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        for (int c = 0; c < 16; c++) begin
            @(posedge ref_clk);
            chan_sel <= 4'(c);
            diff_pair <= 4'($urandom);
            gain_sel <= 3'(c);
            ref_from_dac <= c[0];
            #1;
            chk(16'(mux_diff), 16'(c < 8 && diff_pair[c / 2]));
            if (mux_diff === 1'b1) begin
                chk(16'({mux_pos, mux_neg}),
                    16'(((c & 14) << 4) | c | 1));
            end else begin
                chk(16'(mux_pos), 16'(c >= 8 ? 8 : c));
            end
            chk(16'(pga_code), 16'(c[2:0] > 5 ? 5 : c[2:0]));
            chk(16'(ref_sel_dac), 16'(c[0]));
        end
        @(posedge ref_clk);
        enable <= 1'b0;
        trig_sel <= 2'h0;
        soft_start <= 1'b1;
        repeat (3) begin
            @(posedge ref_clk);
            #1;
            chk({14'h0, core_powerdown, busy | core_start}, 16'h0002);
        end
        @(posedge ref_clk);
        soft_start <= 1'b0;
        enable <= 1'b1;
        for (int i = 0; i < 24; i++) begin
            conv(2'(i), i == 0 ? 12'h000 : i == 1 ? 12'hFFF : 12'($urandom),
                i % 6 == 5, i < 4);
        end
        final_report();
    end
    initial begin
        #(25 * 40000);
        mismatches++;
        final_report();
    end
endmodule
`default_nettype wire
